// ### rtl/two_wire_bus_share.sv
// Two-wire bus sharing: arbitration against one external master and
// chip-select, byte-enable and acknowledge service for its accesses.
// Assumes the partner's hold request drives BUS_GRANT_N and
// BUS_DRIVEN_N feeds its hold acknowledge; select table is static.
//
// Contract
// - No own requests or bus-driven under external master; BUS_REQUEST_N still asserts there while a request is pending.
// - Capture address and direction once, then ignore.
// - Select and byte enables assert on falling edge.
// - First acknowledge on rising edge.
// - Beats two to four on consecutive rising edges; the select's wait states, if set, precede each beat.
// - Acknowledge drops, then selects drop on falling edge.
// - Grant wired to hold request, bus-driven to hold acknowledge.
// - Grant and pending request drive bus-driven low.
// - Withdrawn grant waits for cycle completion.
// - Whole burst counts as one bus cycle.
// - Granted with request: assert bus-driven, pulse start.
// - While granted, keep bus-driven and outputs driven.
// - Grant gone at cycle end: negate bus-driven.
// - Granted without request: implicit, bus left undriven.
// - Request during implicit mastership starts access at once.
// - On release, negate bus-driven and float outputs.
// - Transfer may start the cycle after grant.
// - Selects use their own ack, enable, wait settings.
// - Release after last transfer on rising edge.
`timescale 1ns/1ns
`default_nettype none
module two_wire_bus_share (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic BUS_GRANT_N,
   input wire logic TRANSFER_START_N_IN,
   input wire logic TRANSFER_IN_PROGRESS_N_IN,
   input wire logic TRANSFER_ACK_N_IN,
   input wire bus_share_pkg::attr_s ATTR_IN,
   input wire bus_share_pkg::cs_table_t CS_TABLE,
   input wire logic REQ_VALID,
   input wire bus_share_pkg::attr_s REQ_ATTR,
   output logic REQ_DONE,
   output logic BUS_CLOCK_OUT,
   output logic BUS_DRIVEN_N,
   output logic BUS_REQUEST_N,
   output logic BUS_OE,
   output logic TRANSFER_START_N_OUT,
   output logic TRANSFER_IN_PROGRESS_N_OUT,
   output bus_share_pkg::attr_s ATTR_OUT,
   output logic [bus_share_pkg::NUM_SELECTS-1:0] CHIP_SELECT_N,
   output logic [3:0] BYTE_ENABLE_N,
   output logic TRANSFER_ACK_N_OUT,
   output logic TRANSFER_ACK_OE
);
   import bus_share_pkg::*;

   logic rst_n;
   logic rise_en;
   logic fall_en;
   logic grant;
   logic want;
   logic launch;
   logic beat;
   pins_s p;
   pins_s pins_raw;
   logic [NUM_SELECTS-1:0] raw_hit;
   logic [NUM_SELECTS-1:0] sel;
   chip_select_control_s sel_cfg;
   share_state_s s;
   share_state_s n;

   ////////////////////////////////////////////////////////////////////
   // Clocking and input synchronisation

   assign pins_raw = '{bus_grant_n: BUS_GRANT_N, transfer_start_n: TRANSFER_START_N_IN,
                       transfer_in_progress_n: TRANSFER_IN_PROGRESS_N_IN,
                       transfer_ack_n: TRANSFER_ACK_N_IN, attr: ATTR_IN};

   pin_sync u_sync (
      .clk(MCLK),
      .rst_raw_n(RST_B),
      .pins_in(pins_raw),
      .rst_n(rst_n),
      .pins(p)
   );

   bus_clock_div u_div (
      .clk(MCLK),
      .rst_n(rst_n),
      .bclk(BUS_CLOCK_OUT),
      .rise_en(rise_en),
      .fall_en(fall_en)
   );

   // Grant low means the partner has dropped its hold request
   assign grant = !p.bus_grant_n;
   assign want = REQ_VALID && !s.done;

   ////////////////////////////////////////////////////////////////////
   // Address decode against the select table

   genvar g;
   generate
      for (g = 0; g < NUM_SELECTS; g++) begin : g_dec
         assign raw_hit[g] = (((s.cap.addr[ADDR_W-1:BASE_LSB] ^ CS_TABLE[g].base)
                              & ~CS_TABLE[g].mask) == '0)
                             && (CS_TABLE[g].external_master_enable || !s.ext_cycle);
      end
   endgenerate

   // Lowest numbered select wins an overlap
   always_comb begin
      sel = '0;
      sel_cfg = '0;
      for (int i = NUM_SELECTS - 1; i >= 0; i--) begin
         if (raw_hit[i]) begin
            sel = '0;
            sel[i] = 1'b1;
            sel_cfg = CS_TABLE[i];
         end
      end
   end

   function automatic logic [3:0] lanes(input logic [1:0] size, input logic [1:0] off);
      unique case (size)
         SIZE_BYTE: lanes = LANES_BYTE0 >> off;
         SIZE_WORD: lanes = off[1] ? LANES_HALF1 : LANES_HALF0;
         SIZE_LONG, SIZE_LINE: lanes = LANES_ALL;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      n = s;
      n.done = 1'b0;
      launch = 1'b0;
      beat = 1'b0;
      if (rise_en) begin
         // Request is asserted while one is pending, no own cycle runs and no start is launched
         n.br_n = !(want && s.own == OWN_IDLE);
         unique case (s.arb)
            ARB_RESET: begin
               n.arb = grant ? ARB_IMPLICIT : ARB_EXTERNAL;
            end
            ARB_IMPLICIT: begin
               if (!grant) begin
                  n.arb = ARB_EXTERNAL;
               end else if (want) begin
                  launch = 1'b1;
               end
            end
            ARB_EXPLICIT: begin
               if (!grant && s.own == OWN_IDLE) begin
                  n.arb = ARB_EXTERNAL;
                  n.bd_n = 1'b1;
                  n.bus_oe = 1'b0;
                  n.ts_n = 1'b1;
                  n.tip_n = 1'b1;
               end else if (grant && s.own == OWN_IDLE && want) begin
                  launch = 1'b1;
               end
            end
            ARB_EXTERNAL: begin
               if (grant && s.cs == CS_IDLE) begin
                  // Partner may only grant once off the bus
                  n.arb = ARB_IMPLICIT;
                  launch = want;
               end
            end
         endcase

         if (s.own == OWN_START) begin
            n.ts_n = 1'b1;
            n.own = OWN_DATA;
         end

         unique case (s.cs)
            CS_IDLE: begin
               if (s.arb == ARB_EXTERNAL && !p.transfer_start_n && !p.transfer_in_progress_n) begin
                  n.cap = p.attr;
                  n.ext_cycle = 1'b1;
                  n.cs = CS_DECODE;
               end
            end
            CS_DECODE: begin
               n.hit = sel;
               n.drive_ack = |sel && sel_cfg.auto_ack;
               n.be_on = |sel && sel_cfg.byte_enable_on;
               n.ws = sel_cfg.wait_states;
               n.wait_left = sel_cfg.wait_states;
               n.zero_ws = sel_cfg.wait_states == '0;
               n.line = s.cap.size_code == SIZE_LINE;
               n.beats_left = (s.cap.size_code == SIZE_LINE) ? LINE_BEATS : SINGLE_BEATS;
               n.cs = CS_SETUP;
            end
            CS_SETUP, CS_DROP: begin
            end
            CS_BEATS: begin
               if (s.drive_ack) begin
                  n.ta_oe = 1'b1;
                  if (s.wait_left != '0) begin
                     n.wait_left = s.wait_left - 4'h1;
                     n.ta_n = 1'b1;
                  end else begin
                     n.ta_n = 1'b0;
                     n.wait_left = s.ws;
                     beat = 1'b1;
                  end
               end else begin
                  beat = !p.transfer_ack_n;
               end
               if (beat) begin
                  n.beats_left = s.beats_left - 3'h1;
                  if (s.beats_left == SINGLE_BEATS) begin
                     n.cs = CS_END;
                  end
               end else if (s.ext_cycle && p.transfer_in_progress_n) begin
                  // Master gave up without acknowledge from anyone
                  n.cs = CS_END;
               end
            end
            CS_END: begin
               n.ta_n = 1'b1;
               n.cs = CS_DROP;
               if (!s.ext_cycle) begin
                  n.tip_n = 1'b1;
               end
            end
         endcase

         if (launch) begin
            n.arb = ARB_EXPLICIT;
            n.bd_n = 1'b0;
            n.bus_oe = 1'b1;
            n.ts_n = 1'b0;
            n.tip_n = 1'b0;
            n.br_n = 1'b1;
            n.attr_out = REQ_ATTR;
            n.own = OWN_START;
            n.cap = REQ_ATTR;
            n.ext_cycle = 1'b0;
            n.cs = CS_DECODE;
         end
      end

      if (fall_en) begin
         if (s.cs == CS_SETUP) begin
            n.cs_n = ~s.hit;
            n.be_n = s.be_on ? ~lanes(s.cap.size_code, s.cap.addr[1:0]) : LANES_ALL;
            n.cs = CS_BEATS;
         end
         if (s.cs == CS_DROP) begin
            n.cs_n = '1;
            n.be_n = LANES_ALL;
            n.ta_oe = 1'b0;
            n.cs = CS_IDLE;
            if (s.own == OWN_DATA) begin
               n.own = OWN_IDLE;
               n.done = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         s <= SHARE_RESET;
      end else begin
         s <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs

   assign REQ_DONE = s.done;
   assign BUS_DRIVEN_N = s.bd_n;
   assign BUS_REQUEST_N = s.br_n;
   assign BUS_OE = s.bus_oe;
   assign TRANSFER_START_N_OUT = s.ts_n;
   assign TRANSFER_IN_PROGRESS_N_OUT = s.tip_n;
   assign ATTR_OUT = s.attr_out;
   assign CHIP_SELECT_N = s.cs_n;
   assign BYTE_ENABLE_N = s.be_n;
   assign TRANSFER_ACK_N_OUT = s.ta_n;
   assign TRANSFER_ACK_OE = s.ta_oe;

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!rst_n);

   sequence s_four_beats;
      !TRANSFER_ACK_N_OUT [*8] ##1 TRANSFER_ACK_N_OUT;
   endsequence

   sequence s_selects_off;
      ##1 (&CHIP_SELECT_N && &BYTE_ENABLE_N);
   endsequence

   chk_ext_no_drive: assert property (s.arb == ARB_EXTERNAL |-> BUS_DRIVEN_N && !BUS_OE)
      else $error("bus-driven or outputs active under external master");

   chk_capture_hold: assert property (s.cs != CS_IDLE |=> $stable(s.cap))
      else $error("captured address changed during burst");

   chk_select_fall: assert property ($rose(~&CHIP_SELECT_N) |-> $past(fall_en))
      else $error("chip select asserted off the falling edge");

   chk_ack_rise: assert property ($fell(TRANSFER_ACK_N_OUT) |-> $past(rise_en) && TRANSFER_ACK_OE)
      else $error("acknowledge asserted off the rising edge");

   chk_line_beats: assert property ($fell(TRANSFER_ACK_N_OUT) && s.line && s.zero_ws
      |-> s_four_beats)
      else $error("line burst acknowledge not held for four beats");

   chk_select_drop: assert property ($rose(TRANSFER_ACK_N_OUT) && s.cs == CS_DROP
      |-> s_selects_off)
      else $error("selects not removed on falling edge after acknowledge");

   chk_grant_start: assert property (rise_en && s.arb == ARB_IMPLICIT && grant && want
      |=> !BUS_DRIVEN_N && !TRANSFER_START_N_OUT ##2 TRANSFER_START_N_OUT)
      else $error("granted request did not start with one start pulse");

   chk_cycle_held: assert property (s.own != OWN_IDLE |-> !BUS_DRIVEN_N && BUS_OE)
      else $error("bus released during a cycle");

   chk_release_end: assert property (rise_en && s.arb == ARB_EXPLICIT && !grant
      && s.own == OWN_IDLE |=> BUS_DRIVEN_N && !BUS_OE)
      else $error("bus not released after grant withdrawn");

   chk_implicit_quiet: assert property (s.arb == ARB_IMPLICIT |-> BUS_DRIVEN_N && !BUS_OE)
      else $error("implicit master drives the bus");

   chk_driven_edge: assert property ($changed(BUS_DRIVEN_N) |-> $past(rise_en))
      else $error("bus-driven changed off a rising bus edge");
endmodule
`default_nettype wire

// ### rtl/bus_share_pkg.sv
// Types and constants for the two-wire bus sharing block.
// Assumes one processor clock; bus clock is derived from it.
package bus_share_pkg;
   localparam int ADDR_W = 32;
   localparam int NUM_SELECTS = 2;
   localparam int BASE_LSB = 16;
   localparam int BASE_W = ADDR_W - BASE_LSB;
   localparam int WS_W = 4;
   localparam int BEATS_W = 3;
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_LINE = 2'h3;
   localparam logic [BEATS_W-1:0] LINE_BEATS = 3'h4;
   localparam logic [BEATS_W-1:0] SINGLE_BEATS = 3'h1;
   localparam logic [3:0] LANES_ALL = 4'hf;
   localparam logic [3:0] LANES_BYTE0 = 4'h8;
   localparam logic [3:0] LANES_HALF0 = 4'hc;
   localparam logic [3:0] LANES_HALF1 = 4'h3;
   localparam logic [1:0] SYNC_RESET = 2'h0;

   typedef enum logic [1:0] {ARB_RESET, ARB_IMPLICIT, ARB_EXPLICIT, ARB_EXTERNAL} arb_e;
   typedef enum logic [2:0] {CS_IDLE, CS_DECODE, CS_SETUP, CS_BEATS, CS_END, CS_DROP} cs_e;
   typedef enum logic [1:0] {OWN_IDLE, OWN_START, OWN_DATA} own_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic rw;
      logic [1:0] size_code;
      logic [1:0] transfer_type;
      logic [2:0] transfer_modifier;
   } attr_s;

   typedef struct packed {
      logic [BASE_W-1:0] base;
      logic [BASE_W-1:0] mask;
      logic external_master_enable;
      logic auto_ack;
      logic byte_enable_on;
      logic [WS_W-1:0] wait_states;
   } chip_select_control_s;

   typedef chip_select_control_s [NUM_SELECTS-1:0] cs_table_t;

   typedef struct packed {
      logic bus_grant_n;
      logic transfer_start_n;
      logic transfer_in_progress_n;
      logic transfer_ack_n;
      attr_s attr;
   } pins_s;

   localparam pins_s PINS_IDLE = '1;

   typedef struct packed {
      arb_e arb;
      cs_e cs;
      own_e own;
      attr_s cap;
      attr_s attr_out;
      logic ext_cycle;
      logic [NUM_SELECTS-1:0] hit;
      logic drive_ack;
      logic be_on;
      logic line;
      logic zero_ws;
      logic [WS_W-1:0] ws;
      logic [WS_W-1:0] wait_left;
      logic [BEATS_W-1:0] beats_left;
      logic bd_n;
      logic br_n;
      logic bus_oe;
      logic ts_n;
      logic tip_n;
      logic [NUM_SELECTS-1:0] cs_n;
      logic [3:0] be_n;
      logic ta_n;
      logic ta_oe;
      logic done;
   } share_state_s;

   localparam share_state_s SHARE_RESET = '{
      arb: ARB_RESET, cs: CS_IDLE, own: OWN_IDLE, cap: '0, attr_out: '0, ext_cycle: 1'b0,
      hit: '0, drive_ack: 1'b0, be_on: 1'b0, line: 1'b0, zero_ws: 1'b0, ws: '0,
      wait_left: '0, beats_left: '0, bd_n: 1'b1, br_n: 1'b1, bus_oe: 1'b0, ts_n: 1'b1,
      tip_n: 1'b1, cs_n: '1, be_n: 4'hf, ta_n: 1'b1, ta_oe: 1'b0, done: 1'b0};
endpackage

// ### rtl/bus_clock_div.sv
// Bus clock divider: bus clock is the processor clock halved.
// Assumes a synchronised active-low reset on the same clock.
`timescale 1ns/1ns
`default_nettype none
module bus_clock_div (
   input wire logic clk,
   input wire logic rst_n,
   output logic bclk,
   output logic rise_en,
   output logic fall_en
);
   import bus_share_pkg::*;

   typedef struct packed {
      logic bclk;
   } div_state_s;

   div_state_s s;
   div_state_s n;

   always_comb begin
      n = s;
      n.bclk = !s.bclk;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Enables mark the processor edge on which the bus clock rises or falls
   assign bclk = s.bclk;
   assign rise_en = !s.bclk;
   assign fall_en = s.bclk;
endmodule
`default_nettype wire

// ### rtl/pin_sync.sv
// Reset release and two-flop synchronisers for all pin inputs.
// Assumes raw pins are asynchronous to the processor clock.
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
   input wire logic clk,
   input wire logic rst_raw_n,
   input wire bus_share_pkg::pins_s pins_in,
   output logic rst_n,
   output bus_share_pkg::pins_s pins
);
   import bus_share_pkg::*;

   typedef struct packed {
      logic [1:0] rst;
      pins_s first;
      pins_s second;
   } sync_state_s;

   sync_state_s s;
   sync_state_s n;

   always_comb begin
      n = s;
      n.rst = {s.rst[0], 1'b1};
      n.first = pins_in;
      n.second = s.first;
   end

   always_ff @(posedge clk or negedge rst_raw_n) begin
      if (!rst_raw_n) begin
         s <= '{rst: SYNC_RESET, first: PINS_IDLE, second: PINS_IDLE};
      end else begin
         s <= n;
      end
   end

   assign rst_n = s.rst[1];
   assign pins = s.second;
endmodule
`default_nettype wire

// ### dv/ext_master_model.sv
// Behavioural model of the single external bus master sharing the bus.
// Assumes the bench calls its tasks and feeds its wires to the block.
`timescale 1ns/1ns
`default_nettype none
module ext_master_model
   import bus_share_pkg::*;
(
   input wire logic mclk,
   input wire logic bclk,
   input wire logic bus_oe,
   input wire logic bd_n,
   input wire logic ts_out_n,
   input wire logic tip_out_n,
   input wire bus_share_pkg::attr_s attr_out,
   input wire logic ta_out_n,
   input wire logic ta_oe,
   output logic hold_request,
   output logic ts_n,
   output logic tip_n,
   output bus_share_pkg::attr_s attr,
   output logic ta_n
);
   logic drive = 1'b0;
   logic my_ts = 1'b1;
   logic my_tip = 1'b1;
   attr_s my_attr = '0;

   initial hold_request = 1'b1;
   // Released lines: strobes pulled up, attributes show the inverse of the last value
   assign ts_n = bus_oe ? ts_out_n : (drive ? my_ts : 1'b1);
   assign tip_n = bus_oe ? tip_out_n : (drive ? my_tip : 1'b1);
   assign attr = bus_oe ? attr_out : (drive ? my_attr : ~my_attr);
   assign ta_n = ta_oe ? ta_out_n : 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   task automatic bus_rise();
      @(posedge bclk);
      @(negedge mclk);
   endtask

   task automatic take();
      hold_request = 1'b1;
      for (int i = 0; i < 40; i++) begin
         bus_rise();
         if (bd_n === 1'b1 && bus_oe === 1'b0) break;
      end
      drive = 1'b1;
   endtask

   task automatic give();
      drive = 1'b0;
      my_tip = 1'b1;
      bus_rise();
      hold_request = 1'b0;
   endtask

   // Line or single access; counts acknowledges seen on the wire
   task automatic access(input attr_s a, input int beats, output int acks);
      acks = 0;
      bus_rise();
      my_attr = a;
      my_ts = 1'b0;
      my_tip = 1'b0;
      bus_rise();
      my_ts = 1'b1;
      bus_rise();
      bus_rise();
      my_attr.addr = ~a.addr;
      for (int i = 0; i < 20; i++) begin
         if (ta_n === 1'b0) acks++;
         if (beats != 0 && acks == beats) break;
         if (beats == 0 && i == 8) break;
         bus_rise();
      end
      // In-progress drops with the rise that ends the last acknowledge
      bus_rise();
      my_tip = 1'b1;
      repeat (3) bus_rise();
   endtask
endmodule
`default_nettype wire

// ### dv/two_wire_bus_share_ext_master_bench.sv
// Self-checking bench for the two-wire bus sharing block.
// Assumes the external master model stands on the far side of the bus.
`timescale 1ns/1ns
`default_nettype none
module two_wire_bus_share_ext_master_bench;
   import bus_share_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic req_valid = 1'b0;
   attr_s req_attr = '0;
   cs_table_t cs_table;
   logic grant_n, ts_n, tip_n, ta_n, req_done, bclk, bd_n, br_n, bus_oe;
   logic ts_out_n, tip_out_n, ta_out_n, ta_oe;
   attr_s attr_in, attr_out;
   logic [NUM_SELECTS-1:0] cs_n;
   logic [3:0] be_n;
   int error_cnt = 0;
   int tests_run = 0;
   int cs0, cs1, bec, tac, bdc, tsc, tpc, bbc, acks;
   logic done_bd;

   always #50 mclk = ~mclk;
   initial begin
      cs_table[0] = '{16'h1000, 16'h0000, 1'b1, 1'b1, 1'b1, 4'h0};
      cs_table[1] = '{16'h2000, 16'h0000, 1'b0, 1'b1, 1'b1, 4'h2};
   end

   two_wire_bus_share DUT (.MCLK(mclk), .RST_B(rst_b), .BUS_GRANT_N(grant_n),
      .TRANSFER_START_N_IN(ts_n), .TRANSFER_IN_PROGRESS_N_IN(tip_n),
      .TRANSFER_ACK_N_IN(ta_n), .ATTR_IN(attr_in), .CS_TABLE(cs_table),
      .REQ_VALID(req_valid), .REQ_ATTR(req_attr), .REQ_DONE(req_done),
      .BUS_CLOCK_OUT(bclk), .BUS_DRIVEN_N(bd_n), .BUS_REQUEST_N(br_n), .BUS_OE(bus_oe),
      .TRANSFER_START_N_OUT(ts_out_n), .TRANSFER_IN_PROGRESS_N_OUT(tip_out_n),
      .ATTR_OUT(attr_out), .CHIP_SELECT_N(cs_n), .BYTE_ENABLE_N(be_n),
      .TRANSFER_ACK_N_OUT(ta_out_n), .TRANSFER_ACK_OE(ta_oe));

   ext_master_model m (.mclk(mclk), .bclk(bclk), .bus_oe(bus_oe), .bd_n(bd_n),
      .ts_out_n(ts_out_n), .tip_out_n(tip_out_n), .attr_out(attr_out),
      .ta_out_n(ta_out_n), .ta_oe(ta_oe), .hold_request(grant_n), .ts_n(ts_n),
      .tip_n(tip_n), .attr(attr_in), .ta_n(ta_n));

   // Low-time counters in MCLK cycles
   always @(negedge mclk) begin
      cs0 += int'(cs_n[0] === 1'b0);
      cs1 += int'(cs_n[1] === 1'b0);
      bec += int'(be_n === 4'h0);
      tac += int'(ta_n === 1'b0);
      bdc += int'(bd_n === 1'b0);
      tsc += int'(bus_oe === 1'b1 && ts_out_n === 1'b0);
      tpc += int'(bus_oe === 1'b1 && tip_out_n === 1'b0);
      bbc += int'(be_n === 4'hb);
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string msg, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic clr();
      {cs0, cs1, bec, tac, bdc, tsc, tpc, bbc} = '0;
   endtask

   function automatic attr_s mk(input logic [31:0] a, input logic [1:0] sz);
      return '{a, 1'b1, sz, 2'h0, 3'h0};
   endfunction

   task automatic req(input attr_s a);
      int i;
      req_attr = a;
      req_valid = 1'b1;
      for (i = 0; i < 200; i++) begin
         @(negedge mclk);
         if (req_done === 1'b1) break;
      end
      if (i == 200) check("request never done", 32'h0, 32'h1);
      done_bd = bd_n;
      @(negedge mclk);
      req_valid = 1'b0;
   endtask

   task automatic s_ext_line();
      m.take();
      clr();
      m.access(mk(32'h1000_0100, SIZE_LINE), 4, acks);
      check("line acks", acks, 4);
      check("ack low time", tac, 8);
      check("select low time", cs0, 10);
      check("lanes low time", bec, 10);
      check("other select", cs1, 0);
      check("bus driven under master", bdc, 0);
   endtask

   task automatic s_disabled();
      clr();
      m.access(mk(32'h2000_0000, SIZE_LONG), 0, acks);
      check("disabled select acks", acks, 0);
      check("disabled select low", cs0 + cs1, 0);
   endtask

   task automatic s_hold_then_grant();
      clr();
      req_attr = mk(32'h1000_0040, SIZE_LONG);
      req_valid = 1'b1;
      repeat (20) @(negedge mclk);
      check("bus driven while held", bdc, 0);
      check("start while held", tsc, 0);
      check("request pin", br_n, 1'b0);
      m.give();
      req(mk(32'h1000_0040, SIZE_LONG));
      check("start pulse", tsc, 2);
      check("single ack", tac, 2);
      check("own in-progress time", tpc, 6);
      check("bus driven at done", done_bd, 1'b0);
      repeat (10) @(negedge mclk);
      check("explicit keeps bus driven", bd_n, 1'b0);
      check("explicit keeps outputs", bus_oe, 1'b1);
      check("own address held", attr_out.addr, 32'h1000_0040);
      check("own in-progress idle", tip_out_n, 1'b1);
   endtask

   task automatic s_withdraw();
      clr();
      fork
         req(mk(32'h1000_0080, SIZE_LINE));
         begin
            for (int i = 0; i < 40 && tsc == 0; i++) @(negedge mclk);
            m.take();
         end
      join
      check("all beats kept", tac, 8);
      check("line in-progress time", tpc, 12);
      check("held until done", done_bd, 1'b0);
      check("released bus driven", bd_n, 1'b1);
      check("released outputs", bus_oe, 1'b0);
   endtask

   task automatic s_implicit();
      m.give();
      clr();
      repeat (20) @(negedge mclk);
      check("implicit bus driven", bdc, 0);
      check("implicit outputs", bus_oe, 1'b0);
      req(mk(32'h2000_0001, SIZE_BYTE));
      check("implicit to explicit", done_bd, 1'b0);
      check("implicit start", tsc, 2);
      check("waited select low time", cs1, 8);
      check("byte lane low time", bbc, 8);
      check("waited ack low time", tac, 2);
      check("waited in-progress time", tpc, 10);
   endtask

   task automatic tally_and_finish();
      $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(negedge mclk);
      rst_b = 1'b1;
      check("reset bus driven", bd_n, 1'b1);
      check("reset selects", cs_n, 2'h3);
      check("reset ack drive", ta_oe, 1'b0);
      s_ext_line();
      s_disabled();
      s_hold_then_grant();
      s_withdraw();
      s_implicit();
      tally_and_finish();
   end

   initial begin
      #3000000;
      error_cnt++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
